/* File: hdl/dslcd_pkg.sv */
// Constants, types and helpers shared by the command controller
package dslcd_pkg;
  localparam int AW    = 21;
  localparam int BW    = 4;
  localparam int NBANK = 16;
  localparam int PAW   = 8;
  localparam int RCW   = 4;
  localparam int DW    = 32;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [PAW-1:0] REG_CMD    = 8'h00;
  localparam logic [PAW-1:0] REG_ADDR   = 8'h04;
  localparam logic [PAW-1:0] REG_STATUS = 8'h08;
  localparam logic [PAW-1:0] REG_MODE   = 8'h0c;
  localparam int CMD_BANK_LSB  = 4;
  localparam int CMD_MASK_BIT  = 8;
  localparam int ST_DLLDUE_BIT = 1;
  localparam int ST_RDHOLD_BIT = 2;
  localparam int ST_MRSW_BIT   = 3;
  localparam int ST_REJ_BIT    = 4;
  localparam int ST_BANK_LSB   = 16;
  localparam int MD_MULTI_BIT  = 16;
  localparam int MD_WMODE_LSB  = 17;
  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MR0_LAT_LSB    = 4;
  localparam int MR0_DLL_BIT    = 8;
  localparam int MR0_MUX_BIT    = 9;
  localparam int MR1_DLLRST_BIT = 5;
  localparam int MR1_MULTI_BIT  = 8;
  localparam int MR2_WMODE_LSB  = 3;
  localparam logic [1:0] SEL_MR0    = 2'h0;
  localparam logic [1:0] SEL_MR1    = 2'h1;
  localparam logic [1:0] SEL_MR2    = 2'h2;
  localparam logic [1:0] SEL_NONE   = 2'h3;
  localparam logic [1:0] WMODE_DUAL = 2'h1;
  localparam logic [1:0] WMODE_QUAD = 2'h2;
  localparam logic [AW-1:0] MR0_USED = 21'h0003ff;
  localparam logic [AW-1:0] MR1_USED = 21'h0007ff;
  localparam logic [AW-1:0] MR2_USED = 21'h0007ff;
  localparam int MUXW = 11;
  localparam logic [9:0] DLL_LOCK_CYC = 10'h200;
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_MRS   = 3'b001,
    OP_READ  = 3'b010,
    OP_WRITE = 3'b011,
    OP_AUTO_REFRESH_CMD  = 3'b100
  } dslcd_op_t;
  typedef enum logic {
    ST_IDLE   = 1'b0,
    ST_SECOND = 1'b1
  } dslcd_state_t;
  // Write-enable and refresh-select levels, in that order
  function automatic logic [1:0] dslcd_pins(input dslcd_op_t op);
    case (op)
      OP_READ:  return 2'h3;
      OP_WRITE: return 2'h1;
      OP_AUTO_REFRESH_CMD:  return 2'h2;
      default:  return 2'h0;
    endcase
  endfunction : dslcd_pins
  function automatic logic [NBANK-1:0] dslcd_banks(input dslcd_op_t op, input logic [BW-1:0] ba,
      input logic [AW-1:0] a, input logic multi, input logic [1:0] wmode);
    logic [NBANK-1:0] one;
    one = 16'h0001 << ba;
    if (op == OP_AUTO_REFRESH_CMD && multi)
      return a[NBANK-1:0];
    else if (op == OP_WRITE && wmode == WMODE_DUAL)
      return one | (16'h0001 << (ba ^ 4'h8));
    else if (op == OP_WRITE && wmode == WMODE_QUAD)
      return (16'h1111 << ba[1:0]);
    else if (op == OP_MRS || op == OP_NONE)
      return 16'h0000;
    return one;
  endfunction : dslcd_banks
endpackage : dslcd_pkg

/* File: hdl/dslcd_bank_timers.sv */
// Per-bank row cycle countdown timers
`timescale 1ns/1ps
module dslcd_bank_timers #(
  parameter int NB  = 16,
  parameter int CW  = 4
) (
  input  wire logic          mclk,
  input  wire logic          rstn,
  input  wire logic [NB-1:0] load,
  input  wire logic [CW-1:0] rowCycle,
  output logic      [NB-1:0] busy
);
  logic [CW-1:0] cnt_q [NB];
  logic [CW-1:0] cnt_d [NB];
  always_comb
  begin
    for (int i = 0; i < NB; i++)
    begin
      busy[i] = (cnt_q[i] != '0);
      if (load[i])
        cnt_d[i] = rowCycle;
      else if (busy[i])
        cnt_d[i] = cnt_q[i] - 1'b1;
      else
        cnt_d[i] = cnt_q[i];
    end
  end
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < NB; i++)
      cnt_q[i] <= rstn ? cnt_d[i] : '0;
  end
  chk_timer_load: assert property (@(posedge mclk) disable iff (!rstn)
    load[0] |=> cnt_q[0] == $past(rowCycle)) else $error("row timer did not load");
endmodule : dslcd_bank_timers

/* File: hdl/dslcd_addr_split.sv */
// Address pin value for broadside or two-part addressing
`timescale 1ns/1ps
module dslcd_addr_split #(
  parameter int AW = 21,
  parameter int MW = 11
) (
  input  wire logic [AW-1:0] fullAddr,
  input  wire logic          muxMode,
  input  wire logic          second,
  output logic      [AW-1:0] pinAddr
);
  always_comb
  begin
    if (!muxMode)
      pinAddr = fullAddr;
    else if (second)
      pinAddr = {{MW{1'b0}}, fullAddr[AW-1:MW]};
    else
      pinAddr = {{(AW-MW){1'b0}}, fullAddr[MW-1:0]};
  end
endmodule : dslcd_addr_split

/* File: hdl/dslcd_ctrl.sv */
// Memory-side command controller with APB register port
`timescale 1ns/1ps
module dslcd_ctrl
  import dslcd_pkg::*;
#(
  parameter int MRS_WAIT_CYC = 12
) (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [dslcd_pkg::PAW-1:0] paddr,
  input  wire logic [dslcd_pkg::DW-1:0]  pwdata,
  output logic      [dslcd_pkg::DW-1:0]  prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           memResetN,
  output logic                           csN,
  output logic                           weN,
  output logic                           refN,
  output logic      [dslcd_pkg::AW-1:0]  memAddr,
  output logic      [dslcd_pkg::BW-1:0]  memBank,
  output logic                           writeMask
);
  import dslcd_pkg::*;
  localparam logic [7:0] MRS_WAIT = 8'(MRS_WAIT_CYC);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dslcd_state_t   state_q, state_d;
  dslcd_op_t      op_q, op_d;
  logic           pend_q, pend_d, rej_q, rej_d, mask_q, mask_d;
  logic [BW-1:0]  bank_q, bank_d;
  logic [AW-1:0]  addr_q, addr_d, sent_q, sent_d;
  logic [AW-1:0]  mr0_q, mr0_d;
  logic           multi_q, multi_d, dllDue_q, dllDue_d;
  logic [1:0]     wmode_q, wmode_d;
  logic [7:0]     mrsCnt_q, mrsCnt_d;
  logic [9:0]     dllCnt_q, dllCnt_d;
  logic           csN_d, weN_d, refN_d, mask_pin_d;
  logic [AW-1:0]  memAddr_d;
  logic [BW-1:0]  memBank_d;
  logic [DW-1:0]  prdata_d;
  logic           pready_d, pslverr_d;
  logic           busy, done, issue, bad, ok, useMux;
  logic [NBANK-1:0] set, bankBusy, load;
  logic [AW-1:0]  issueAddr, splitIn, splitOut;
  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign busy = pend_q || state_q == ST_SECOND;
  assign done = psel && penable && pready;
  always_comb
  begin
    pready_d  = psel && penable && !pready;
    pslverr_d = 1'b0;
    prdata_d  = '0;
    if (paddr == REG_CMD)
    begin
      pslverr_d = pwrite && (busy || pwdata[2:0] == OP_NONE || pwdata[2:0] > OP_AUTO_REFRESH_CMD);
      prdata_d  = {23'h000000, mask_q, bank_q, 1'b0, op_q};
    end
    else if (paddr == REG_ADDR)
      prdata_d = {11'h000, addr_q};
    else if (paddr == REG_STATUS)
    begin
      prdata_d = {bankBusy, 11'h000, rej_q, mrsCnt_q != '0, dllCnt_q != '0, dllDue_q, busy};
    end
    else if (paddr == REG_MODE)
      prdata_d = {13'h0000, wmode_q, multi_q, 6'h00, mr0_q[9:0]};
    else
      pslverr_d = 1'b1;
    if (!pready_d)
    begin
      pslverr_d = 1'b0;
      prdata_d  = '0;
    end
  end
  // ----------------------------------------------------------------
  // Command engine
  // ----------------------------------------------------------------
  assign set = dslcd_banks(op_q, bank_q, addr_q, multi_q, wmode_q);
  assign useMux = mr0_q[MR0_MUX_BIT] && op_q != OP_AUTO_REFRESH_CMD;
  assign issueAddr = op_q != OP_MRS ? addr_q :
                     bank_q[1:0] == SEL_MR0 ? addr_q & MR0_USED :
                     bank_q[1:0] == SEL_MR1 ? addr_q & MR1_USED : addr_q & MR2_USED;
  assign splitIn = state_q == ST_SECOND ? sent_q : issueAddr;
  always_comb
  begin
    bad = op_q == OP_MRS && (bank_q[1:0] == SEL_NONE || (bank_q[1:0] == SEL_MR0 && !addr_q[MR0_DLL_BIT]
          && addr_q[RCW-1:0] != addr_q[MR0_LAT_LSB +: RCW]));
    if (op_q == OP_MRS)
      ok = bankBusy == '0 && mrsCnt_q == '0;
    else if (op_q == OP_READ)
      ok = (set & bankBusy) == '0 && mrsCnt_q == '0 && dllCnt_q == '0;
    else
      ok = (set & bankBusy) == '0 && mrsCnt_q == '0;
    issue = state_q == ST_IDLE && pend_q && !bad && ok;
  end
  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    bank_d = bank_q;
    mask_d = mask_q;
    addr_d = addr_q;
    pend_d = pend_q;
    rej_d = rej_q;
    sent_d = sent_q;
    mr0_d = mr0_q;
    multi_d = multi_q;
    wmode_d = wmode_q;
    dllDue_d = dllDue_q;
    mrsCnt_d = mrsCnt_q != '0 ? mrsCnt_q - 1'b1 : mrsCnt_q;
    dllCnt_d = dllCnt_q != '0 ? dllCnt_q - 1'b1 : dllCnt_q;
    load = '0;
    csN_d = 1'b1;
    weN_d = 1'b1;
    refN_d = 1'b1;
    memBank_d = '0;
    mask_pin_d = writeMask;
    memAddr_d = '0;
    if (done && pwrite && !pslverr && paddr == REG_CMD)
    begin
      op_d = dslcd_op_t'(pwdata[2:0]);
      bank_d = pwdata[CMD_BANK_LSB +: BW];
      mask_d = pwdata[CMD_MASK_BIT];
      pend_d = 1'b1;
      rej_d = 1'b0;
    end
    else if (done && pwrite && paddr == REG_ADDR)
      addr_d = pwdata[AW-1:0];
    if (state_q == ST_SECOND)
    begin
      memAddr_d = splitOut;
      state_d = ST_IDLE;
    end
    else if (pend_q && bad)
    begin
      pend_d = 1'b0;
      rej_d = 1'b1;
    end
    else if (issue)
    begin
      pend_d = 1'b0;
      csN_d = 1'b0;
      {weN_d, refN_d} = dslcd_pins(op_q);
      memBank_d = op_q == OP_MRS ? {2'b00, bank_q[1:0]} : bank_q;
      memAddr_d = splitOut;
      mask_pin_d = mask_q;
      sent_d = issueAddr;
      load = set;
      if (useMux)
        state_d = ST_SECOND;
      if (op_q == OP_MRS)
      begin
        mrsCnt_d = MRS_WAIT;
        if (bank_q[1:0] == SEL_MR0)
        begin
          mr0_d = issueAddr;
          if (issueAddr[MR0_DLL_BIT] && !mr0_q[MR0_DLL_BIT])
            dllDue_d = 1'b1;
        end
        else if (bank_q[1:0] == SEL_MR1)
        begin
          multi_d = issueAddr[MR1_MULTI_BIT];
          if (issueAddr[MR1_DLLRST_BIT])
          begin
            dllCnt_d = DLL_LOCK_CYC;
            dllDue_d = 1'b0;
          end
        end
        else
          wmode_d = issueAddr[MR2_WMODE_LSB +: 2];
      end
    end
  end
  dslcd_bank_timers #(
    .NB       (NBANK),
    .CW       (RCW)
  ) u_timers (
    .mclk     (mclk),
    .rstn     (rstn),
    .load     (load),
    .rowCycle (mr0_q[RCW-1:0]),
    .busy     (bankBusy)
  );
  dslcd_addr_split #(
    .AW       (AW),
    .MW       (MUXW)
  ) u_split (
    .fullAddr (splitIn),
    .muxMode  (state_q == ST_SECOND || useMux),
    .second   (state_q == ST_SECOND),
    .pinAddr  (splitOut)
  );
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      {pend_q, rej_q, mask_q, multi_q, dllDue_q} <= '0;
      {bank_q, wmode_q, mrsCnt_q, dllCnt_q} <= '0;
      {addr_q, sent_q, mr0_q, memAddr} <= '0;
      {csN, weN, refN} <= 3'h7;
      {memBank, writeMask, memResetN} <= '0;
      {prdata, pready, pslverr} <= '0;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      {pend_q, rej_q, mask_q, multi_q, dllDue_q} <= {pend_d, rej_d, mask_d, multi_d, dllDue_d};
      {bank_q, wmode_q, mrsCnt_q, dllCnt_q} <= {bank_d, wmode_d, mrsCnt_d, dllCnt_d};
      {addr_q, sent_q, mr0_q, memAddr} <= {addr_d, sent_d, mr0_d, memAddr_d};
      {csN, weN, refN} <= {csN_d, weN_d, refN_d};
      {memBank, writeMask, memResetN} <= {memBank_d, mask_pin_d, 1'b1};
      {prdata, pready, pslverr} <= {prdata_d, pready_d, pslverr_d};
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  chk_pin_decode: assert property (issue |=> !csN && {weN, refN} == dslcd_pins($past(op_q)))
    else $error("command pins do not match opcode");
  chk_mrs_idle: assert property (issue && op_q == OP_MRS |-> bankBusy == '0)
    else $error("mode load with a bank busy");
  chk_mrs_wait: assert property (!csN && !weN && !refN |=> csN[*2] ##0 mrsCnt_q == MRS_WAIT - 8'h2)
    else $error("mode load wait not started");
  chk_mrs_bank: assert property (!csN && !weN && !refN |-> memBank[3:2] == 2'b00)
    else $error("upper bank bits high in mode load");
  chk_row_gap: assert property (issue |-> (set & bankBusy) == '0)
    else $error("bank accessed inside row cycle");
  chk_dll_hold: assert property (issue && op_q == OP_READ |-> dllCnt_q == '0)
    else $error("read during loop lock time");
  chk_second_part: assert property (state_q == ST_SECOND |=> csN && memAddr[AW-1:MUXW] == '0)
    else $error("second address part malformed");
  chk_single_cmd: assert property (issue |=> !pend_q)
    else $error("command issued twice");
  chk_dll_reject: assert property (pend_q && bad && state_q == ST_IDLE |=> rej_q && csN)
    else $error("bad mode load not refused");
  chk_apb_ready: assert property (psel && penable && !pready |=> pready)
    else $error("bus access not answered");
  chk_one_cycle: assert property (!csN |=> csN)
    else $error("chip select held for two cycles");
  chk_idle_bank: assert property (csN |-> memBank == '0)
    else $error("bank pins active without a command");
  chk_mrs_reserved: assert property (!csN && !weN && !refN |-> memAddr[AW-1:MUXW] == '0)
    else $error("reserved address bits high in mode load");
  // Checked on load rather than busy, so a zero row cycle still exercises them
  chk_dual_write: assert property (issue && op_q == OP_WRITE && wmode_q == WMODE_DUAL |->
    $countones(load) == 2 && load[bank_q] && load[bank_q ^ 4'h8]) else $error("dual write bank set wrong");
  chk_quad_write: assert property (issue && op_q == OP_WRITE && wmode_q == WMODE_QUAD |->
    $countones(load) == 4 && load[bank_q]) else $error("quad write bank set wrong");
  chk_multi_bank: assert property (issue && op_q == OP_AUTO_REFRESH_CMD && multi_q |-> load == addr_q[NBANK-1:0])
    else $error("multibank refresh bank set wrong");
  chk_rej_clear: assert property (done && pwrite && !pslverr && paddr == REG_CMD |=> !rej_q)
    else $error("refused flag not cleared by new command");
  chk_dev_reset: assert property (@(posedge mclk) disable iff (1'b0) !rstn |=> !memResetN)
    else $error("device reset not driven low");
  // ----------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------
  cov_mrs: cover property (!csN && !weN && !refN);
  cov_mux_read: cover property (issue && op_q == OP_READ && useMux);
  cov_multi_ref: cover property (issue && op_q == OP_AUTO_REFRESH_CMD && multi_q);
  cov_dll_wait: cover property (pend_q && op_q == OP_READ && dllCnt_q != '0);
  cov_quad_write: cover property (issue && op_q == OP_WRITE && wmode_q == WMODE_QUAD);
endmodule : dslcd_ctrl

/* File: verification/dslcd_mem_model.sv */
// Behavioural memory device that decodes the controller's command pins
`timescale 1ns/1ps
module dslcd_mem_model
  import dslcd_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     memResetN,
  input  wire logic                     csN,
  input  wire logic                     weN,
  input  wire logic                     refN,
  input  wire logic [dslcd_pkg::AW-1:0] memAddr,
  input  wire logic [dslcd_pkg::BW-1:0] memBank,
  input  wire logic                     writeMask,
  output logic                          seen,
  output logic      [28:0]              seenCmd
);
  // ----------------------------------------
  // Command decode and mode registers
  // ----------------------------------------
  logic [AW-1:0] modeConfigZero;
  logic [AW-1:0] modeConfigOne;
  logic [AW-1:0] modeConfigTwo;
  logic          contQ;
  logic [6:0]    headQ;
  logic [10:0]   lowQ;
  logic          maskQ;
  logic [2:0]    op;

  always_comb
  begin
    case ({weN, refN})
      2'b00:   op = 3'h1;
      2'b11:   op = 3'h2;
      2'b01:   op = 3'h3;
      default: op = 3'h4;
    endcase
  end

  // Report each command once, after its second address part when split
  always @(posedge mclk)
  begin
    seen <= 1'b0;
    if (!memResetN)
    begin
      modeConfigZero <= '0;
      modeConfigOne  <= '0;
      modeConfigTwo  <= '0;
      contQ          <= 1'b0;
    end
    else if (contQ)
    begin
      contQ   <= 1'b0;
      seen    <= 1'b1;
      seenCmd <= {headQ, memAddr[9:0], lowQ, maskQ};
    end
    else if (!csN)
    begin
      if (op == 3'h1 && memBank[1:0] == 2'h0)
        modeConfigZero <= memAddr;
      if (op == 3'h1 && memBank[1:0] == 2'h1)
        modeConfigOne <= memAddr & ~21'h000020;
      if (op == 3'h1 && memBank[1:0] == 2'h2)
        modeConfigTwo <= memAddr;
      if (modeConfigZero[9] && op != 3'h4)
      begin
        contQ <= 1'b1;
        headQ <= {op, memBank};
        lowQ  <= memAddr[10:0];
        maskQ <= writeMask;
      end
      else
      begin
        seen    <= 1'b1;
        seenCmd <= {op, memBank, memAddr, writeMask};
      end
    end
  end
endmodule : dslcd_mem_model

/* File: verification/dslcd_ctrl_tb_top.sv */
// Self-checking bench for the command controller
`timescale 1ns/1ps
module dslcd_ctrl_tb_top;
  import dslcd_pkg::*;
  logic          mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [PAW-1:0] paddr  = '0;
  logic [DW-1:0]  pwdata = '0;
  logic [DW-1:0]  prdata, rd;
  logic           pready, pslverr, memResetN, csN, weN, refN, writeMask, seen, err;
  logic [AW-1:0]  memAddr;
  logic [BW-1:0]  memBank;
  logic [28:0]    seenCmd;
  logic [28:0]    expQ[$];
  logic [31:0]    rnd = 32'h6de51ebc;
  int             errors = 0, checks = 0, n;

  always #20 mclk = ~mclk;

  dslcd_ctrl #(.MRS_WAIT_CYC(12)) dslcd_ctrl_i (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memResetN(memResetN), .csN(csN), .weN(weN), .refN(refN), .memAddr(memAddr), .memBank(memBank),
    .writeMask(writeMask));
  dslcd_mem_model dslcd_mem_model_i (.mclk(mclk), .memResetN(memResetN), .csN(csN), .weN(weN), .refN(refN),
    .memAddr(memAddr), .memBank(memBank), .writeMask(writeMask), .seen(seen), .seenCmd(seenCmd));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task conclude;
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s got %h", $time, what, got);
    end
  endtask : chk

  // Values sampled at the edge see pre-edge outputs, as a clocking block would
  task apb(input logic w, input logic [PAW-1:0] a, input logic [DW-1:0] d);
    int k;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      errors++;
      $display("[FAIL] %0t bus access not answered", $time);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task waitIdle;
    n = 0;
    do
    begin
      apb(1'b0, REG_STATUS, '0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 600);
    if (rd[0] !== 1'b0)
    begin
      errors++;
      $display("[FAIL] %0t controller stayed busy", $time);
    end
  endtask : waitIdle

  task cmd(input logic [2:0] op, input logic [3:0] bank, input logic [20:0] addr, input logic mask,
           input logic [20:0] expAddr, input logic take);
    waitIdle();
    apb(1'b1, REG_ADDR, {11'h0, addr});
    if (take)
      expQ.push_back({op, bank, expAddr, mask});
    apb(1'b1, REG_CMD, {23'h0, mask, bank, 1'b0, op});
    chk(32'(err), 32'h0, "cmd write error");
  endtask : cmd

  // ----------------------------------------
  // Command monitor and scenarios
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (seen === 1'b1)
    begin
      checks++;
      if (expQ.size() == 0 || seenCmd !== expQ[0])
      begin
        errors++;
        $display("[FAIL] %0t unexpected command %h", $time, seenCmd);
      end
      if (expQ.size() != 0)
        void'(expQ.pop_front());
    end
  end

  initial
  begin
    repeat (30000) @(posedge mclk);
    errors++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    apb(1'b0, REG_STATUS, '0);
    chk(rd, 32'h0, "status after reset");
    apb(1'b1, REG_MODE, 32'hffffffff);
    apb(1'b0, REG_MODE, '0);
    chk(rd, 32'h0, "mode read only");
    apb(1'b0, 8'h10, '0);
    chk(32'(err), 32'h1, "unmapped error");
    cmd(3'h1, 4'h0, 21'h1ff133, 1'b0, 21'h000133, 1'b1);
    waitIdle();
    chk(32'(rd[1]), 32'h1, "loop reset due");
    apb(1'b0, REG_MODE, '0);
    chk(32'(rd[9:0]), 32'h133, "mode shadow");
    cmd(3'h1, 4'h1, 21'h000020, 1'b0, 21'h000020, 1'b1);
    cmd(3'h2, 4'h5, 21'h012345, 1'b1, 21'h012345, 1'b1);
    apb(1'b0, REG_STATUS, '0);
    chk(32'(rd[2:1]), 32'h2, "read held after loop reset");
    for (int i = 0; i < 12; i++)
    begin
      rnd = lfsr(rnd);
      cmd(3'(2 + i % 3), rnd[3:0], rnd[24:4], rnd[25], rnd[24:4], 1'b1);
    end
    cmd(3'h1, 4'h0, 21'h000034, 1'b0, 21'h0, 1'b0);
    waitIdle();
    chk(32'(rd[4]), 32'h1, "dll off mismatch refused");
    cmd(3'h1, 4'h3, 21'h000001, 1'b0, 21'h0, 1'b0);
    waitIdle();
    chk(32'(rd[4]), 32'h1, "select three refused");
    cmd(3'h1, 4'h0, 21'h000044, 1'b0, 21'h000044, 1'b1);
    cmd(3'h1, 4'h0, 21'h000333, 1'b0, 21'h000333, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      cmd(3'(2 + i % 3), rnd[7:4], rnd[28:8], rnd[1], rnd[28:8], 1'b1);
    end
    cmd(3'h1, 4'h0, 21'h00013f, 1'b0, 21'h00013f, 1'b1);
    cmd(3'h1, 4'h2, 21'h000008, 1'b0, 21'h000008, 1'b1);
    cmd(3'h3, 4'h5, 21'h000abc, 1'b0, 21'h000abc, 1'b1);
    waitIdle();
    chk(32'(rd[31:16]), 32'h2020, "dual write banks");
    cmd(3'h1, 4'h2, 21'h000010, 1'b0, 21'h000010, 1'b1);
    cmd(3'h3, 4'h6, 21'h000123, 1'b1, 21'h000123, 1'b1);
    waitIdle();
    chk(32'(rd[31:16]), 32'h4444, "quad write banks");
    cmd(3'h1, 4'h1, 21'h000100, 1'b0, 21'h000100, 1'b1);
    cmd(3'h4, 4'h3, 21'h00a005, 1'b0, 21'h00a005, 1'b1);
    waitIdle();
    chk(32'(rd[31:16]), 32'ha005, "multibank refresh banks");
    n = 0;
    while (expQ.size() != 0 && n < 2000)
    begin
      @(posedge mclk);
      n++;
    end
    chk(32'(expQ.size()), 32'h0, "commands missing");
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(32'(memResetN), 32'h0, "device reset low");
    rstn <= 1'b1;
    apb(1'b0, REG_MODE, '0);
    chk(rd, 32'h0, "mode cleared by reset");
    conclude();
  end
endmodule : dslcd_ctrl_tb_top
